/* hw/mpc_consts.vh */
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH
// =====================================
// register byte offsets
`define MPC_OFS_PINCFG 8'h00
`define MPC_OFS_TRIG 8'h04
`define MPC_OFS_CTRL 8'h08
`define MPC_OFS_CONF 8'h0C
`define MPC_OFS_STAT 8'h10
// =====================================
// pin configuration fields
`define MPC_PC_IN_EN 0
`define MPC_PC_IN_FN 1
`define MPC_PC_CHSEL 5
`define MPC_PC_OUT_FN 9
`define MPC_PC_OUT_EN 13
`define MPC_PC_W 14
`define MPC_RST_PINCFG 14'h0000
// =====================================
// software trigger fields (write one; the unlock field takes the key)
`define MPC_TR_FAULT 0
`define MPC_TR_PROT 1
`define MPC_TR_CLR 2
`define MPC_TR_LOAD 3
`define MPC_TR_RESET 4
`define MPC_TR_MHI 6
`define MPC_TR_MLO 8
`define MPC_TR_UNLOCK 12
`define MPC_UNLOCK_KEY 4'h5
// =====================================
// control fields
`define MPC_CT_IOUT 0
`define MPC_CT_VOUT 2
`define MPC_CT_FGEN 4
`define MPC_CT_NVM 6
`define MPC_CT_LOCK 7
// =====================================
// channel configuration fields
`define MPC_CF_SYNC 0
`define MPC_CF_VPD 2
// =====================================
// input function codes
`define MPC_FN_FAULT 4'h2
`define MPC_FN_IOUT 4'h3
`define MPC_FN_VOUT 4'h4
`define MPC_FN_PROT 4'h5
`define MPC_FN_CLR 4'h7
`define MPC_FN_LOAD 4'h8
`define MPC_FN_FGEN 4'h9
`define MPC_FN_MARGIN 4'hA
`define MPC_FN_RESET 4'hB
`define MPC_FN_NVM 4'hC
`define MPC_FN_LOCK 4'hD
// =====================================
// output function codes
`define MPC_OF_MEMBUSY 4'h1
`define MPC_OF_CH1BUSY 4'h4
`define MPC_OF_CH0BUSY 4'h7
`define MPC_OF_WIN1 4'h8
`define MPC_OF_WIN0 4'hB
// =====================================
// cycles after reset before the power-on level is taken
`define MPC_INIT_CYCLES 2'h3
`endif

/* hw/mpc_pin_control.v */
`timescale 1ns/10ps
`default_nettype none
`include "mpc_consts.vh"
// Behaviour
// - A 1 in the input-enable bit makes the pin an input, a 1 in the output-enable bit an output if input-enable is 0.
// - Channel-specific pin actions touch only the channels in the channel-select field.
// - After power-up the pin level is taken once and its command executed.
// - Out of reset with nothing stored the pin is mapped to no function.
// - A software bit is ignored while the pin is mapped to the same function.
// - Codes 0010, 0101, 0111 fire fault-dump, protect, clear on a falling edge only.
// - Codes 0011/0100 power current/voltage outputs down on fall and up on rise.
// - Code 1001 stops/starts waveforms, code 1010 fires margin-low/high, on fall/rise.
// - Code 1011 resets the device on a complete low pulse, whether mapped from storage or by a register write.
// - Code 1100 allows/blocks memory programming, 1101 unlocks/locks register writes.
// - Pin actions obey the sync-mode constraint on load like their software counterparts, but not the register lock.
// - As an output the pin shows the status chosen by the output function code.
module mpc_pin_control #(
	parameter ADDR_W = 8
) (
	input wire clk,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire pinIn,
	output reg pinOut,
	output reg pinOeN,
	input wire [`MPC_PC_W-1:0] storedCfg,
	input wire storedCfgValid,
	input wire memBusy,
	input wire ch0Busy,
	input wire ch1Busy,
	input wire win0,
	input wire win1,
	output reg [1:0] ioutPd,
	output reg [1:0] voutPd,
	output reg [1:0] voutPdMode,
	output reg [1:0] funcGenRun,
	output reg [1:0] marginHigh,
	output reg [1:0] marginLow,
	output reg [1:0] loadPulse,
	output reg clearPulse,
	output reg protectPulse,
	output reg faultDumpPulse,
	output reg deviceResetPulse,
	output reg nvmProgAllow,
	output reg regLock
);

// =====================================
// state
reg pinS1;
reg pinS2;
reg pinPrev;
reg [1:0] initCnt;
reg initFire;
reg lowSeen;
reg [`MPC_PC_W-1:0] cfg;
reg [1:0] syncMode;
reg [31:0] next_prdata;

function hit;
	input [ADDR_W-1:0] a;
	input [7:0] ofs;
	begin
		hit = (a == ofs[ADDR_W-1:0]);
	end
endfunction

// =====================================
// decode
wire inEn = cfg[`MPC_PC_IN_EN];
wire outEn = cfg[`MPC_PC_OUT_EN] & ~inEn;
wire [3:0] fc = inEn ? cfg[`MPC_PC_IN_FN+:4] : 4'h0;
wire [3:0] ofc = cfg[`MPC_PC_OUT_FN+:4];
wire [1:0] chs = cfg[`MPC_PC_CHSEL+:2];
wire fallE = initFire ? ~pinS2 : (pinPrev & ~pinS2);
wire riseE = initFire ? pinS2 : (~pinPrev & pinS2);
wire pFault = (fc == `MPC_FN_FAULT);
wire pIout = (fc == `MPC_FN_IOUT);
wire pVout = (fc == `MPC_FN_VOUT);
wire pProt = (fc == `MPC_FN_PROT);
wire pClr = (fc == `MPC_FN_CLR);
wire pLoad = (fc == `MPC_FN_LOAD);
wire pFgen = (fc == `MPC_FN_FGEN);
wire pMargin = (fc == `MPC_FN_MARGIN);
wire pReset = (fc == `MPC_FN_RESET);
wire pNvm = (fc == `MPC_FN_NVM);
wire pLock = (fc == `MPC_FN_LOCK);

// =====================================
// bus decode
wire acc = psel & penable & pready;
wire wr = acc & pwrite;
wire mapped = hit(paddr, `MPC_OFS_PINCFG) | hit(paddr, `MPC_OFS_TRIG) | hit(paddr, `MPC_OFS_CTRL)
	| hit(paddr, `MPC_OFS_CONF) | hit(paddr, `MPC_OFS_STAT);
// a locked map still takes the unlock and reset fields of the trigger register
wire wrCfg = wr & ~regLock & hit(paddr, `MPC_OFS_PINCFG);
wire wrCtl = wr & ~regLock & hit(paddr, `MPC_OFS_CTRL);
wire wrConf = wr & ~regLock & hit(paddr, `MPC_OFS_CONF);
wire wrTrig = wr & hit(paddr, `MPC_OFS_TRIG);
wire trFull = wrTrig & ~regLock;
wire swFault = trFull & pwdata[`MPC_TR_FAULT] & ~pFault;
wire swProt = trFull & pwdata[`MPC_TR_PROT] & ~pProt;
wire swClr = trFull & pwdata[`MPC_TR_CLR] & ~pClr;
wire swLoad = trFull & pwdata[`MPC_TR_LOAD] & ~pLoad;
wire [1:0] swMhi = (trFull & ~pMargin) ? pwdata[`MPC_TR_MHI+:2] : 2'h0;
wire [1:0] swMlo = (trFull & ~pMargin) ? pwdata[`MPC_TR_MLO+:2] : 2'h0;
wire swReset = wrTrig & pwdata[`MPC_TR_RESET] & ~pReset;
wire swUnlock = wrTrig & (pwdata[`MPC_TR_UNLOCK+:4] == `MPC_UNLOCK_KEY) & ~pLock;

always @* begin
	next_prdata = 32'h0000_0000;
	if (hit(paddr, `MPC_OFS_PINCFG)) begin
		next_prdata = {18'h0_0000, cfg};
	end else if (hit(paddr, `MPC_OFS_CTRL)) begin
		next_prdata = {24'h00_0000, regLock, nvmProgAllow, funcGenRun, voutPd, ioutPd};
	end else if (hit(paddr, `MPC_OFS_CONF)) begin
		next_prdata = {28'h000_0000, voutPdMode, syncMode};
	end else if (hit(paddr, `MPC_OFS_STAT)) begin
		next_prdata = {25'h000_0000, initFire, pinS2, win1, win0, ch1Busy, ch0Busy, memBusy};
	end
end

// =====================================
// bus slave: one wait state, data latched in setup
always @(posedge clk) begin
	if (rst) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end else begin
		pready <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & ~mapped;
		if (psel & ~penable) begin
			prdata <= next_prdata;
		end
	end
end

// =====================================
// pin synchroniser and power-on sequencing
always @(posedge clk) begin
	if (rst) begin
		pinS1 <= 1'b0;
		pinS2 <= 1'b0;
		pinPrev <= 1'b0;
		initCnt <= 2'h0;
		initFire <= 1'b0;
	end else begin
		pinS1 <= pinIn;
		pinS2 <= pinS1;
		pinPrev <= pinS2;
		// level taken once, after the synchroniser has filled
		initFire <= (initCnt == `MPC_INIT_CYCLES - 2'h1);
		if (initCnt != `MPC_INIT_CYCLES) begin
			initCnt <= initCnt + 2'h1;
		end
	end
end

// =====================================
// configuration, software and pin actions
always @(posedge clk) begin
	if (rst) begin
		cfg <= `MPC_RST_PINCFG;
		syncMode <= 2'h0;
		voutPdMode <= 2'h0;
		ioutPd <= 2'h0;
		voutPd <= 2'h0;
		funcGenRun <= 2'h0;
		marginHigh <= 2'h0;
		marginLow <= 2'h0;
		loadPulse <= 2'h0;
		clearPulse <= 1'b0;
		protectPulse <= 1'b0;
		faultDumpPulse <= 1'b0;
		deviceResetPulse <= 1'b0;
		nvmProgAllow <= 1'b0;
		regLock <= 1'b0;
		lowSeen <= 1'b0;
	end else begin
		// a reset mapping survives only if it was stored
		if (initCnt == 2'h0 && storedCfgValid) begin
			cfg <= storedCfg;
		end else if (wrCfg) begin
			cfg <= pwdata[`MPC_PC_W-1:0];
		end
		if (wrConf) begin
			syncMode <= pwdata[`MPC_CF_SYNC+:2];
			voutPdMode <= pwdata[`MPC_CF_VPD+:2];
		end
		// one-shot outputs
		faultDumpPulse <= swFault | (pFault & fallE);
		protectPulse <= swProt | (pProt & fallE);
		clearPulse <= swClr | (pClr & fallE);
		// load only reaches channels in sync mode, from either source
		loadPulse <= ({2{swLoad}} | ((pLoad & fallE) ? chs : 2'h0)) & syncMode;
		marginLow <= swMlo | ((pMargin & fallE) ? chs : 2'h0);
		marginHigh <= swMhi | ((pMargin & riseE) ? chs : 2'h0);
		// reset waits for the pin to come back high
		deviceResetPulse <= swReset | (pReset & riseE & lowSeen);
		if (pReset & fallE) begin
			lowSeen <= 1'b1;
		end else if (riseE | ~pReset) begin
			lowSeen <= 1'b0;
		end
		// level outputs: pin owner first, software only when the pin does not own them
		if (pIout) begin
			if (fallE) begin
				ioutPd <= ioutPd | chs;
			end else if (riseE) begin
				ioutPd <= ioutPd & ~chs;
			end
		end else if (wrCtl) begin
			ioutPd <= pwdata[`MPC_CT_IOUT+:2];
		end
		if (pVout) begin
			if (fallE) begin
				voutPd <= voutPd | chs;
			end else if (riseE) begin
				voutPd <= voutPd & ~chs;
			end
		end else if (wrCtl) begin
			voutPd <= pwdata[`MPC_CT_VOUT+:2];
		end
		if (pFgen) begin
			if (fallE) begin
				funcGenRun <= funcGenRun & ~chs;
			end else if (riseE) begin
				funcGenRun <= funcGenRun | chs;
			end
		end else if (wrCtl) begin
			funcGenRun <= pwdata[`MPC_CT_FGEN+:2];
		end
		if (pNvm) begin
			if (fallE) begin
				nvmProgAllow <= 1'b1;
			end else if (riseE) begin
				nvmProgAllow <= 1'b0;
			end
		end else if (wrCtl) begin
			nvmProgAllow <= pwdata[`MPC_CT_NVM];
		end
		if (pLock) begin
			if (fallE) begin
				regLock <= 1'b0;
			end else if (riseE) begin
				regLock <= 1'b1;
			end
		end else if (swUnlock) begin
			regLock <= 1'b0;
		end else if (wrCtl) begin
			regLock <= pwdata[`MPC_CT_LOCK];
		end
	end
end

// =====================================
// pin as status output
always @(posedge clk) begin
	if (rst) begin
		pinOut <= 1'b0;
		pinOeN <= 1'b1;
	end else begin
		pinOeN <= ~outEn;
		case (ofc)
			`MPC_OF_MEMBUSY: pinOut <= memBusy;
			`MPC_OF_CH1BUSY: pinOut <= ch1Busy;
			`MPC_OF_CH0BUSY: pinOut <= ch0Busy;
			`MPC_OF_WIN1: pinOut <= win1;
			`MPC_OF_WIN0: pinOut <= win0;
			default: pinOut <= 1'b0;
		endcase
	end
end

endmodule // mpc_pin_control
`default_nettype wire

/* bench/mpc_pin_drv.sv */
`timescale 1ns/10ps
`default_nettype none
// ====
// board side of the multifunction pin
module mpc_pin_drv (
	input wire logic clk,
	input wire logic lvl,
	input wire logic slow,
	output logic pin
);
	logic lvlD;
	// slow mode lags a clock, as a weak board driver would
	always @(posedge clk) begin
		lvlD <= lvl;
		pin <= slow ? lvlD : lvl;
	end
endmodule // mpc_pin_drv
`default_nettype wire

/* bench/mpc_pin_control_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mpc_consts.vh"
// ====
// checker
module mpc_pin_control_monitor #(
	parameter ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pinIn,
	input wire logic pinOut,
	input wire logic pinOeN,
	input wire logic [`MPC_PC_W-1:0] storedCfg,
	input wire logic storedCfgValid,
	input wire logic memBusy,
	input wire logic [1:0] ioutPd,
	input wire logic clearPulse,
	input wire logic protectPulse,
	input wire logic faultDumpPulse,
	input wire logic deviceResetPulse,
	input wire logic regLock
);
	logic [13:0] cfg;
	logic rstD;
	// shadow of the pin configuration
	always_ff @(posedge clk) begin
		rstD <= rst;
		if (rst)
			cfg <= '0;
		else if (rstD && storedCfgValid)
			cfg <= storedCfg;
		else if (psel && penable && pready && pwrite && !regLock && paddr == `MPC_OFS_PINCFG)
			cfg <= pwdata[13:0];
	end
	// reset code needs a full low pulse: a rise after a fall must fire reset
	logic armed;
	always_ff @(posedge clk) begin
		if (rst || cfg[4:0] != 5'h17)
			armed <= 1'b0;
		else if ($fell(pinIn))
			armed <= 1'b1;
		else if ($rose(pinIn))
			armed <= 1'b0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_rdy; pready |=> !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready too long");
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("pready late");
	property p_errRdy; pslverr |-> pready; endproperty
	a_errRdy: assert property (p_errRdy) else $error("pslverr alone");
	property p_errMap; pready && paddr > 8'h10 |-> pslverr; endproperty
	a_errMap: assert property (p_errMap) else $error("no pslverr");
	// two synchroniser flops, then the action register: seen high three edges on
	property p_clr; $fell(pinIn) && cfg[4:0] == 5'h0f |-> ##3 clearPulse; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_pdn; $fell(pinIn) && cfg[4:0] == 5'h07 |-> ##3 (ioutPd & cfg[6:5]) == cfg[6:5]; endproperty
	a_pdn: assert property (p_pdn) else $error("no power-down");
	property p_pup; $rose(pinIn) && cfg[4:0] == 5'h07 |-> ##3 (ioutPd & cfg[6:5]) == 2'b00; endproperty
	a_pup: assert property (p_pup) else $error("no power-up");
	property p_off;
		$fell(pinIn) && !cfg[0] |-> ##3 !(clearPulse || protectPulse || faultDumpPulse);
	endproperty
	a_off: assert property (p_off) else $error("unmapped pin acted");
	property p_rstPin; $rose(pinIn) && armed && cfg[4:0] == 5'h17 |-> ##3 deviceResetPulse; endproperty
	a_rstPin: assert property (p_rstPin) else $error("no reset");
	property p_oe; cfg[13] && !cfg[0] && $stable(cfg) |=> !pinOeN; endproperty
	a_oe: assert property (p_oe) else $error("pin not driven");
	property p_stat; !pinOeN && cfg[12:9] == 4'h1 && $stable(cfg) && $stable(memBusy) |=> pinOut == $past(memBusy); endproperty
	a_stat: assert property (p_stat) else $error("wrong status");
	c_clr: cover property (clearPulse);
	c_rst: cover property (deviceResetPulse);
	c_err: cover property (pslverr);
endmodule // mpc_pin_control_monitor
bind mpc_pin_control mpc_pin_control_monitor #(.ADDR_W(ADDR_W)) u_mon (
	.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .pinIn, .pinOut, .pinOeN,
	.storedCfg, .storedCfgValid, .memBusy, .ioutPd, .clearPulse, .protectPulse, .faultDumpPulse,
	.deviceResetPulse, .regLock
);
`default_nettype wire

/* bench/mpc_pin_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mpc_consts.vh"
module mpc_pin_control_tb;
	logic clk, rst, psel, penable, pwrite, pslverr, pready, pinIn, pinOut, pinOeN, err;
	logic storedCfgValid, pinLvl, slowPin, deviceResetPulse, clearPulse, protectPulse, faultDumpPulse;
	logic nvmProgAllow, regLock;
	logic [4:0] stat;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [13:0] storedCfg;
	logic [1:0] ioutPd, voutPd, voutPdMode, funcGenRun, marginHigh, marginLow, loadPulse;
	int failCount, numChecks, cyc;
	// {enable, code, level, pulses seen, levels after}
	logic [23:0] tab [27] = '{24'hbc_0000, 24'hb8_8000, 24'h94_0000, 24'h92_0000, 24'hac_0000, 24'ha9_0000,
		24'h9c_0000, 24'h98_0080, 24'ha4_0080, 24'ha0_00a0, 24'hcc_00a8, 24'hc8_00a0, 24'hd4_08a0,
		24'hd0_02a0, 24'h9c_0020, 24'hc0_2020, 24'hc4_0020, 24'he0_0022, 24'he4_0020, 24'hd8_0020,
		24'hdc_4020, 24'h80_0020, 24'h3c_0020, 24'h38_0020, 24'hec_0021, 24'he8_0020, 24'hec_0021};
	mpc_pin_drv PD (.clk(clk), .lvl(pinLvl), .slow(slowPin), .pin(pinIn));
	mpc_pin_control DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
		.pinOut(pinOut), .pinOeN(pinOeN), .storedCfg(storedCfg), .storedCfgValid(storedCfgValid),
		.memBusy(stat[0]), .ch1Busy(stat[1]), .ch0Busy(stat[2]), .win1(stat[3]), .win0(stat[4]),
		.ioutPd(ioutPd), .voutPd(voutPd), .voutPdMode(voutPdMode), .funcGenRun(funcGenRun),
		.marginHigh(marginHigh), .marginLow(marginLow), .loadPulse(loadPulse), .clearPulse(clearPulse),
		.protectPulse(protectPulse), .faultDumpPulse(faultDumpPulse), .deviceResetPulse(deviceResetPulse),
		.nvmProgAllow(nvmProgAllow), .regLock(regLock));
	// ====
	// common tasks
	task automatic closeOut();
		$display("checks %0d mismatches %0d", numChecks, failCount);
		if (failCount == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			failCount++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the bench timeout ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic step(input logic [23:0] e);
		logic [17:0] acc;
		apb(1'b1, `MPC_OFS_PINCFG, {23'h0, 4'h2, e[22:19], e[23]});
		@(posedge clk);
		pinLvl <= e[18];
		slowPin <= ~slowPin;
		acc = '0;
		repeat (9) begin
			@(negedge clk);
			acc[17:8] = acc[17:8] | {faultDumpPulse, protectPulse, clearPulse, deviceResetPulse, loadPulse,
				marginHigh, marginLow};
		end
		acc[7:0] = {ioutPd, voutPd, funcGenRun, nvmProgAllow, regLock};
		chk({14'h0, acc}, {14'h0, e[17:0]});
		@(posedge clk);
	endtask
	// ====
	// scenarios
	task automatic tInit();
		logic acc;
		acc = 1'b0;
		repeat (9) begin
			@(negedge clk);
			acc = acc | clearPulse;
		end
		chk({31'h0, acc}, 32'h0000_0001);
		@(posedge clk);
		storedCfgValid <= 1'b0;
		apb(1'b0, `MPC_OFS_PINCFG, 32'h0);
		chk(q, 32'h0000_000f);
	endtask
	task automatic tApb();
		apb(1'b0, 8'h14, 32'h0);
		chk({q[30:0], err}, 32'h0000_0001);
		apb(1'b1, `MPC_OFS_CONF, 32'h0000_0002);
		apb(1'b0, `MPC_OFS_CONF, 32'h0);
		chk(q, 32'h0000_0002);
	endtask
	task automatic tOut();
		logic [3:0] codes [5] = '{`MPC_OF_MEMBUSY, `MPC_OF_CH1BUSY, `MPC_OF_CH0BUSY, `MPC_OF_WIN1, `MPC_OF_WIN0};
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `MPC_OFS_PINCFG, {18'h0, 1'b1, codes[i], 9'h0});
			stat <= 5'h01 << i;
			repeat (4) @(posedge clk);
			chk({30'h0, pinOeN, pinOut}, 32'h0000_0001);
			stat <= 5'h00;
			repeat (4) @(posedge clk);
			chk({30'h0, pinOeN, pinOut}, 32'h0000_0000);
		end
	endtask
	task automatic tLock();
		apb(1'b1, `MPC_OFS_CTRL, 32'h0);
		apb(1'b0, `MPC_OFS_CTRL, 32'h0);
		chk(q, 32'h0000_0088);
	endtask
	// mid-run reset with nothing stored: the mapping must come back empty
	task automatic tReset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, `MPC_OFS_PINCFG, 32'h0);
		chk(q, 32'h0000_0000);
		pinLvl <= 1'b0;
		repeat (9) @(posedge clk);
		chk({24'h0, ioutPd, voutPd, funcGenRun, nvmProgAllow, regLock}, 32'h0000_0000);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			failCount++;
			closeOut();
		end
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{rst, storedCfgValid} = 2'b11;
		{psel, penable, pwrite, pinLvl, slowPin} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		stat = 5'h00;
		storedCfg = 14'h000f;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		tInit();
		tApb();
		tOut();
		for (int i = 0; i < 27; i++)
			step(tab[i]);
		tLock();
		tReset();
		closeOut();
	end
endmodule // mpc_pin_control_tb
`default_nettype wire
